// ---- shc_host_model.sv ----
// host-side serial master model for the configuration port
`timescale 1ns/1ps
module shc_host_model (
  input  wire logic i_ref_clk,
  input  wire logic i_sdo_pin,
  input  wire logic i_sdo_oe,
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_sdi
);
  // ****************************************
  // frame engine
  // ****************************************
  // half of the 160 ns link period, in ref clocks
  localparam int HALF = 4;
  logic [7:0] rd_data;
  logic       oe_ok;

  // sclk stands still low and sdi sits at its pull-down level outside frames
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi  = 1'b0;
  end

  // sel_n high sends the same clocks with chip select left inactive
  task automatic xfer(input logic sel_n, input logic [15:0] frm, input int nbits);
    int i;
    @(negedge i_ref_clk);
    o_cs_n  = sel_n;
    oe_ok   = 1'b1;
    rd_data = 8'h00;
    for (i = 0; i < nbits; i++) begin
      o_sdi = frm[15-i];
      repeat (HALF) @(negedge i_ref_clk);
      if (i >= 8) begin
        rd_data = {rd_data[6:0], i_sdo_pin};
        oe_ok   = oe_ok & i_sdo_oe;
      end
      o_sclk = 1'b1;
      repeat (HALF) @(negedge i_ref_clk);
      o_sclk = 1'b0;
    end
    repeat (HALF) @(negedge i_ref_clk);
    o_cs_n = 1'b1;
    o_sdi  = 1'b0;
  endtask : xfer
endmodule : shc_host_model

// ---- shc_pkg.sv ----
// constants and types for the host serial configuration port
// What this block does
// - serial input captured on serial clock rise
// - serial output changes on serial clock fall
// - read shifts out the selected register
// - serial output released when transfer completes
// - register reset pin restores all defaults
// - new interrupt drives interrupt pin low
// - cleared interrupt enable keeps interrupt inactive
// - hardware mode reuses serial pins as straps
// - jitter select pins pick fifo or disable in hardware mode
package shc_pkg;

  // ****************************************
  // frame layout: rw bit, address, data
  // ****************************************
  localparam int          SHC_ADDR_BITS   = 7;
  localparam int          SHC_DATA_BITS   = 8;
  localparam logic [4:0]  SHC_HDR_LAST    = 5'h07;
  localparam logic [4:0]  SHC_FRAME_LAST  = 5'h0f;
  localparam int          SHC_SYNC_WIDTH  = 9;

  // ****************************************
  // register offsets, fields, reset values
  // ****************************************
  localparam logic [6:0]  SHC_ADR_CHAN_CTRL = 7'h00;
  localparam logic [6:0]  SHC_ADR_INT_STAT  = 7'h01;
  localparam logic [6:0]  SHC_ADR_CFG_A     = 7'h02;
  localparam logic [6:0]  SHC_ADR_CFG_B     = 7'h03;
  localparam int          SHC_BIT_INT_EN    = 0;
  localparam logic [7:0]  SHC_RST_CHAN_CTRL = 8'h00;
  localparam logic [7:0]  SHC_RST_INT_STAT  = 8'h00;
  localparam logic [7:0]  SHC_RST_CFG_A     = 8'h00;
  localparam logic [7:0]  SHC_RST_CFG_B     = 8'h00;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    SHC_FIFO_16,
    SHC_FIFO_32,
    SHC_FIFO_128,
    SHC_FIFO_NONE
  } shc_depth_e;

  typedef struct packed {
    logic       ja_disable;
    shc_depth_e depth;
  } shc_ja_s;

  typedef enum logic [1:0] {
    SHC_ST_IDLE,
    SHC_ST_ADDR,
    SHC_ST_DATA,
    SHC_ST_DONE
  } shc_state_e;

endpackage : shc_pkg

// ---- shc_port.sv ----
// host serial configuration port with hardware-mode strap decode
`timescale 1ns/1ps
module shc_port (
  input  wire logic            i_ref_clk,
  input  wire logic            i_sys_rst,
  input  wire logic            i_host_mode,
  input  wire logic            i_cs_n,
  input  wire logic            i_sclk,
  input  wire logic            i_host_serial_in,
  input  wire logic            i_host_serial_out,
  input  wire logic            i_int_pin,
  input  wire logic            i_reg_rst_n,
  input  wire logic            i_jitter_select_a,
  input  wire logic            i_jitter_select_b,
  input  wire logic [7:0]      i_alarm_event,
  output logic                 o_host_serial_out,
  output logic                 o_host_serial_out_oe,
  output logic                 o_int_n,
  output logic                 o_int_oe,
  output logic [7:0]           o_chan_ctrl,
  output logic [7:0]           o_cfg_a,
  output logic                 o_receive_clock_invert,
  output logic                 o_transmit_clock_invert,
  output logic                 o_receiver_enable_strap,
  output logic                 o_receiver_monitor_strap,
  output logic                 o_mute_on_signal_loss,
  output shc_pkg::shc_ja_s     o_ja_cfg
);

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic shc_pkg::shc_ja_s ja_decode(input logic [1:0] sel);
    shc_pkg::shc_ja_s res;
    res.depth      = shc_pkg::shc_depth_e'(sel);
    res.ja_disable = (sel == 2'h3);
    return res;
  endfunction : ja_decode

  logic [7:0] chan_ctrl;
  logic [7:0] int_stat;
  logic [7:0] cfg_a;
  logic [7:0] cfg_b;

  function automatic logic [7:0] read_reg(input logic [6:0] adr);
    case (adr)
      shc_pkg::SHC_ADR_CHAN_CTRL: read_reg = chan_ctrl;
      shc_pkg::SHC_ADR_INT_STAT:  read_reg = int_stat;
      shc_pkg::SHC_ADR_CFG_A:     read_reg = cfg_a;
      shc_pkg::SHC_ADR_CFG_B:     read_reg = cfg_b;
      default:                    read_reg = 8'h00;
    endcase
  endfunction : read_reg

  // ****************************************
  // pin synchronisation and edge finding
  // ****************************************
  logic [8:0] pins_s;
  logic       cs_s;
  logic       sclk_s;
  logic       sdi_s;
  logic       sdo_pin_s;
  logic       int_pin_s;
  logic       rst_n_s;
  logic       host_s;
  logic [1:0] ja_s;
  logic       sclk_q;
  logic       rise;
  logic       fall;
  logic       reg_rst;

  shc_sync #(
    .WIDTH (shc_pkg::SHC_SYNC_WIDTH)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_host_mode, i_cs_n, i_sclk, i_host_serial_in, i_host_serial_out,
                 i_int_pin, i_reg_rst_n, i_jitter_select_a, i_jitter_select_b}),
    .o_sync    (pins_s)
  );

  assign {host_s, cs_s, sclk_s, sdi_s, sdo_pin_s, int_pin_s, rst_n_s} = pins_s[8:2];
  assign ja_s    = pins_s[1:0];
  assign rise    = sclk_s & ~sclk_q;
  assign fall    = ~sclk_s & sclk_q;
  assign reg_rst = ~rst_n_s;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk_s;
    end
  end

  // ****************************************
  // serial transfer engine
  // ****************************************
  shc_pkg::shc_state_e state;
  logic [4:0]          cnt;
  logic [15:0]         shift_in;
  logic [7:0]          shift_out;
  logic                is_read;
  logic [6:0]          rd_addr;
  logic                wr_fire;
  logic [6:0]          wr_addr;
  logic [7:0]          wr_data;
  logic [7:0]          rd_word;

  assign rd_addr = {shift_in[5:0], sdi_s};
  assign wr_addr = shift_in[13:7];
  assign wr_data = {shift_in[6:0], sdi_s};
  assign rd_word = read_reg(rd_addr);
  assign wr_fire = (state == shc_pkg::SHC_ST_DATA) && rise && !is_read && !cs_s && host_s
                   && !reg_rst && (cnt == shc_pkg::SHC_FRAME_LAST);

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || reg_rst || !host_s || cs_s) begin
      state                <= shc_pkg::SHC_ST_IDLE;
      cnt                  <= 5'h00;
      is_read              <= 1'b0;
      shift_in             <= 16'h0000;
      shift_out            <= 8'h00;
      // data bit held on abort so it only moves on a fall; oe alone frees the pin
      o_host_serial_out    <= i_sys_rst ? 1'b0 : o_host_serial_out;
      o_host_serial_out_oe <= 1'b0;
    end else begin
      if (rise && state != shc_pkg::SHC_ST_DONE) begin
        shift_in <= {shift_in[14:0], sdi_s};
        cnt      <= cnt + 5'h01;
      end
      case (state)
        shc_pkg::SHC_ST_IDLE: begin
          if (rise) begin
            is_read <= sdi_s;
            state   <= shc_pkg::SHC_ST_ADDR;
          end
        end
        shc_pkg::SHC_ST_ADDR: begin
          if (rise && cnt == shc_pkg::SHC_HDR_LAST) begin
            shift_out <= read_reg(rd_addr);
            state     <= shc_pkg::SHC_ST_DATA;
          end
        end
        shc_pkg::SHC_ST_DATA: begin
          if (fall && is_read) begin
            o_host_serial_out    <= shift_out[7];
            shift_out            <= {shift_out[6:0], 1'b0};
            o_host_serial_out_oe <= 1'b1;
          end
          // release once the last bit is taken
          if (rise && cnt == shc_pkg::SHC_FRAME_LAST) begin
            o_host_serial_out_oe <= 1'b0;
            state                <= shc_pkg::SHC_ST_DONE;
          end
        end
        shc_pkg::SHC_ST_DONE: begin
          state <= shc_pkg::SHC_ST_DONE;
        end
        default: begin
          state <= shc_pkg::SHC_ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // command registers
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || reg_rst) begin
      chan_ctrl <= shc_pkg::SHC_RST_CHAN_CTRL;
      cfg_a     <= shc_pkg::SHC_RST_CFG_A;
      cfg_b     <= shc_pkg::SHC_RST_CFG_B;
    end else if (wr_fire) begin
      case (wr_addr)
        shc_pkg::SHC_ADR_CHAN_CTRL: chan_ctrl <= wr_data;
        shc_pkg::SHC_ADR_CFG_A:     cfg_a     <= wr_data;
        shc_pkg::SHC_ADR_CFG_B:     cfg_b     <= wr_data;
        default:                    chan_ctrl <= chan_ctrl;
      endcase
    end
  end

  // sticky status: an event in the clearing cycle survives
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || reg_rst) begin
      int_stat <= shc_pkg::SHC_RST_INT_STAT;
    end else if (wr_fire && wr_addr == shc_pkg::SHC_ADR_INT_STAT) begin
      int_stat <= (int_stat & ~wr_data) | i_alarm_event;
    end else begin
      int_stat <= int_stat | i_alarm_event;
    end
  end

  // ****************************************
  // interrupt pin and hardware-mode straps
  // ****************************************
  logic int_req;

  assign int_req = (|int_stat) & chan_ctrl[shc_pkg::SHC_BIT_INT_EN];

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_int_n                  <= 1'b1;
      o_int_oe                 <= 1'b0;
      o_chan_ctrl              <= shc_pkg::SHC_RST_CHAN_CTRL;
      o_cfg_a                  <= shc_pkg::SHC_RST_CFG_A;
      o_receive_clock_invert   <= 1'b0;
      o_transmit_clock_invert  <= 1'b0;
      o_receiver_enable_strap  <= 1'b0;
      o_receiver_monitor_strap <= 1'b0;
      o_mute_on_signal_loss    <= 1'b0;
      o_ja_cfg                 <= ja_decode(2'h0);
    end else begin
      // new interrupt pulls the pin low
      o_int_n                  <= ~(int_req & host_s);
      o_int_oe                 <= host_s;
      o_chan_ctrl              <= chan_ctrl;
      o_cfg_a                  <= cfg_a;
      o_receive_clock_invert   <= ~host_s & cs_s;
      o_transmit_clock_invert  <= ~host_s & sclk_s;
      o_receiver_enable_strap  <= ~host_s & sdi_s;
      o_receiver_monitor_strap <= ~host_s & sdo_pin_s;
      o_mute_on_signal_loss    <= ~host_s & int_pin_s;
      // strap pins choose the fifo in hardware mode
      o_ja_cfg                 <= host_s ? ja_decode(cfg_b[1:0]) : ja_decode(ja_s);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_cs_ignore: assert property (cs_s |=> !o_host_serial_out_oe)
    else $error("serial output driven while deselected");
  chk_sample_rise: assert property (
    (rise && !cs_s && host_s && !reg_rst && state == shc_pkg::SHC_ST_ADDR)
      |=> shift_in[0] == $past(sdi_s))
    else $error("serial input not captured on rise");
  chk_out_on_fall: assert property (
    $changed(o_host_serial_out) |-> $past(fall))
    else $error("serial output changed away from a falling edge");
  chk_read_load: assert property (
    (rise && !cs_s && host_s && !reg_rst && state == shc_pkg::SHC_ST_ADDR
      && cnt == shc_pkg::SHC_HDR_LAST) |=> shift_out == $past(rd_word))
    else $error("read data not loaded from selected register");
  chk_release_done: assert property (
    o_host_serial_out_oe |-> is_read && state == shc_pkg::SHC_ST_DATA)
    else $error("serial output driven outside read data phase");
  chk_reg_reset: assert property (
    reg_rst |=> chan_ctrl == shc_pkg::SHC_RST_CHAN_CTRL && cfg_b == shc_pkg::SHC_RST_CFG_B)
    else $error("register reset did not restore defaults");
  chk_int_fall: assert property (
    (int_req && host_s) |=> !o_int_n)
    else $error("interrupt pin not pulled low");
  chk_int_mask: assert property (
    !chan_ctrl[shc_pkg::SHC_BIT_INT_EN] |=> o_int_n)
    else $error("interrupt asserted while disabled");
  chk_hw_straps: assert property (
    !host_s |=> o_receive_clock_invert == $past(cs_s) && !o_host_serial_out_oe)
    else $error("hardware mode strap not followed");
  chk_ja_decode: assert property (
    (!host_s && ja_s == 2'h2) |=> o_ja_cfg.depth == shc_pkg::SHC_FIFO_128 && !o_ja_cfg.ja_disable)
    else $error("jitter select decode wrong");
  chk_abandon: assert property (
    (cs_s && state != shc_pkg::SHC_ST_IDLE)
      |=> state == shc_pkg::SHC_ST_IDLE && !o_host_serial_out_oe)
    else $error("partial transfer not abandoned");

endmodule : shc_port

// ---- shc_port_test.sv ----
// self-checking testbench for the host serial configuration port
`timescale 1ns/1ps
module shc_port_test;
  logic              clk = 1'b0, rst = 1'b1, host_mode = 1'b1, reg_rst_n = 1'b1;
  logic              ja_a = 1'b0, ja_b = 1'b0, receiver_monitor_strap = 1'b0, mute = 1'b0;
  logic [7:0]        alarm = 8'h00;
  logic              cs_n, sclk, host_serial_in, so, so_oe, int_n, int_oe, so_pin, int_pin;
  logic              rx_inv, tx_inv, rx_en, rx_mon, mute_o;
  logic [7:0]        chan_ctrl, cfg_a;
  shc_pkg::shc_ja_s  ja_cfg;
  int                errors = 0, checks = 0, k;

  // in host mode a released serial-out line shows the inverse, never a stale copy; in hardware mode it shows the strap
  assign so_pin  = so_oe ? so : (host_mode ? ~so : receiver_monitor_strap);
  assign int_pin = int_oe ? int_n : mute;

  always #10 clk = ~clk;

  shc_host_model i_shc_host_model (.i_ref_clk(clk), .i_sdo_pin(so_pin), .i_sdo_oe(so_oe),
    .o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(host_serial_in));

  shc_port i_shc_port (.i_ref_clk(clk), .i_sys_rst(rst), .i_host_mode(host_mode),
    .i_cs_n(cs_n), .i_sclk(sclk), .i_host_serial_in(host_serial_in), .i_host_serial_out(so_pin),
    .i_int_pin(int_pin), .i_reg_rst_n(reg_rst_n), .i_jitter_select_a(ja_a),
    .i_jitter_select_b(ja_b), .i_alarm_event(alarm), .o_host_serial_out(so),
    .o_host_serial_out_oe(so_oe), .o_int_n(int_n), .o_int_oe(int_oe),
    .o_chan_ctrl(chan_ctrl), .o_cfg_a(cfg_a), .o_receive_clock_invert(rx_inv),
    .o_transmit_clock_invert(tx_inv), .o_receiver_enable_strap(rx_en),
    .o_receiver_monitor_strap(rx_mon), .o_mute_on_signal_loss(mute_o), .o_ja_cfg(ja_cfg));

  // ****************************************
  // access tasks
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [6:0] adr, input logic [7:0] val);
    i_shc_host_model.xfer(1'b0, {1'b0, adr, val}, 16);
  endtask : wr

  // read data and the drive enable during every data bit
  task automatic rd(input logic [6:0] adr, input logic [7:0] exp);
    i_shc_host_model.xfer(1'b0, {1'b1, adr, 8'h00}, 16);
    check(i_shc_host_model.rd_data, exp);
    check({7'h00, i_shc_host_model.oe_ok}, 8'h01);
  endtask : rd

  // sync plus output register latency
  task automatic settle();
    repeat (6) @(negedge clk);
  endtask : settle

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // whole run is about 40 us; five times that is a hang
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    settle();
    check(chan_ctrl, shc_pkg::SHC_RST_CHAN_CTRL);
    check(cfg_a, shc_pkg::SHC_RST_CFG_A);
    check({6'h00, int_n, int_oe}, 8'h03);
    wr(shc_pkg::SHC_ADR_CHAN_CTRL, 8'hfe);
    wr(shc_pkg::SHC_ADR_CFG_A, 8'ha5);
    wr(shc_pkg::SHC_ADR_CFG_B, 8'h3c);
    rd(shc_pkg::SHC_ADR_CHAN_CTRL, 8'hfe);
    rd(shc_pkg::SHC_ADR_CFG_A, 8'ha5);
    rd(shc_pkg::SHC_ADR_CFG_B, 8'h3c);
    rd(7'h05, 8'h00);
    check(chan_ctrl, 8'hfe);
    settle();
    check({7'h00, so_oe}, 8'h00);
    i_shc_host_model.xfer(1'b1, {1'b0, shc_pkg::SHC_ADR_CFG_A, 8'h11}, 16);
    rd(shc_pkg::SHC_ADR_CFG_A, 8'ha5);
    i_shc_host_model.xfer(1'b0, {1'b0, shc_pkg::SHC_ADR_CFG_A, 8'h22}, 12);
    rd(shc_pkg::SHC_ADR_CFG_A, 8'ha5);
    i_shc_host_model.xfer(1'b0, {1'b1, shc_pkg::SHC_ADR_CFG_A, 8'h00}, 11);
    check({5'h00, i_shc_host_model.rd_data[2:0]}, 8'h05);
    check({7'h00, i_shc_host_model.oe_ok}, 8'h01);
    settle();
    check({7'h00, so_oe}, 8'h00);
    // event with interrupt enable cleared
    alarm = 8'h04;
    @(negedge clk);
    alarm = 8'h00;
    settle();
    check({7'h00, int_n}, 8'h01);
    rd(shc_pkg::SHC_ADR_INT_STAT, 8'h04);
    wr(shc_pkg::SHC_ADR_CHAN_CTRL, 8'h01);
    settle();
    check({7'h00, int_n}, 8'h00);
    wr(shc_pkg::SHC_ADR_INT_STAT, 8'h04);
    settle();
    check({7'h00, int_n}, 8'h01);
    reg_rst_n = 1'b0;
    settle();
    check(chan_ctrl, shc_pkg::SHC_RST_CHAN_CTRL);
    check(cfg_a, shc_pkg::SHC_RST_CFG_A);
    reg_rst_n = 1'b1;
    settle();
    rd(shc_pkg::SHC_ADR_CFG_A, shc_pkg::SHC_RST_CFG_A);
    // hardware mode: strap decode
    host_mode = 1'b0;
    for (k = 0; k < 4; k++) begin
      ja_a = k[1];
      ja_b = k[0];
      settle();
      check({5'h00, ja_cfg}, {5'h00, k[1] & k[0], k[1:0]});
    end
    for (k = 0; k < 2; k++) begin
      i_shc_host_model.o_cs_n = k[0];
      i_shc_host_model.o_sclk = ~k[0];
      i_shc_host_model.o_sdi  = k[0];
      receiver_monitor_strap = ~k[0];
      mute  = k[0];
      settle();
      check({3'h0, rx_inv, tx_inv, rx_en, rx_mon, mute_o},
            {3'h0, k[0], ~k[0], k[0], ~k[0], k[0]});
      check({6'h00, int_oe, so_oe}, 8'h00);
    end
    tally_and_finish();
  end
endmodule : shc_port_test

// ---- shc_sync.sv ----
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module shc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_sys_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second stage
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule : shc_sync
